// *** usrt_top.sv ***
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Overview of operation
// - Setting transmit enable makes the block drive the serial output pin.
// - Synchronous mode drives or samples the transfer clock pin to time bits.
// - Writing the data register loads the transmit buffer and starts a send.
// - Buffer moves to shifter when idle or right after last stop bit.
// - Data bits above the character length are dropped on write.
// - Nine-bit mode takes the ninth-bit control as data bit eight.
// - Buffer-empty flag is high while the buffer is empty, low once written.
// - Buffer-empty request is a level while flag and its enable are set.
// - Transmit-complete sets when frame is out and buffer holds nothing.
// - Transmit-complete clears on service acknowledge or a written one.
// - Transmit-complete request is raised while flag and enable are set.
// - Parity enable inserts the parity bit after data, before stop.
// - After disable, keep sending until shifter and buffer are empty.
// - Receive enable takes over the serial input pin.
// - Receive starts on a valid start bit; second stop bit is ignored.
// - First stop bit moves the character into the receive buffer.
// - Unused upper bits of a received character read as zero.
// - Baud down-counter reloads at zero or low-byte write, ticks at zero.
// - Frame is start, data LSB first, optional parity, stops; idle high.
// - Parity is xor of data bits, inverted for odd parity.
// - Receive-complete flag is high while unread data sits in the buffer.
module usrt_top (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic      [1:0]  hresp,
    // Interrupt requests and service acknowledge
    output logic             irq_buf_empty,
    output logic             irq_tx_complete,
    input  wire logic        irq_tx_complete_ack,
    // Serial pins
    output logic             serial_out_pin_o,
    output logic             serial_out_pin_oe,
    input  wire logic        serial_in_pin,
    output logic             rx_pin_owned,
    input  wire logic        transfer_clock_pin_i,
    output logic             transfer_clock_pin_o,
    output logic             transfer_clock_pin_oe
);
    import usrt_pkg::*;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic [7:0] addr_ff;
    logic       wr_ph_ff, rd_ph_ff, rd_rdy_ff;
    logic [31:0] hrdata_ff;
    logic       accept, wr_en, rd_cap;
    logic [31:0] rd_mux;

    assign accept    = hsel && hready && htrans[1];
    assign hreadyout = !(rd_ph_ff && !rd_rdy_ff);
    assign hresp     = HRESP_OKAY;
    assign hrdata    = hrdata_ff;
    assign wr_en     = wr_ph_ff;
    assign rd_cap    = rd_ph_ff && !rd_rdy_ff;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            addr_ff   <= 8'h00;
            wr_ph_ff  <= 1'b0;
            rd_ph_ff  <= 1'b0;
            rd_rdy_ff <= 1'b0;
        end else begin
            rd_rdy_ff <= rd_cap;
            if (hreadyout) begin
                wr_ph_ff <= accept && hwrite;
                rd_ph_ff <= accept && !hwrite;
                if (accept) begin
                    addr_ff <= haddr[7:0];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_cap) begin
            hrdata_ff <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0]  ctrl_b_ff, ctrl_c_ff;
    logic [11:0] baud_div_ff;
    logic        u2x_ff;
    logic        wr_data, wr_lo, rd_data;
    logic [2:0]  csz;
    logic [3:0]  nbits;
    logic [8:0]  cmask;

    assign wr_data = wr_en && addr_ff == ADDR_DATA;
    assign wr_lo   = wr_en && addr_ff == ADDR_BAUD_LO;
    assign rd_data = rd_cap && addr_ff == ADDR_DATA;
    assign csz     = {ctrl_b_ff[CB_CSZ2], ctrl_c_ff[CC_CSZ_HI], ctrl_c_ff[CC_CSZ_LO]};
    assign nbits   = (csz == CSZ_NINE) ? 4'h9 : CSZ_BASE + {2'b00, csz[1:0]};
    assign cmask   = 9'h1ff >> (4'h9 - nbits);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_b_ff   <= 8'h00;
            ctrl_c_ff   <= CTRL_C_RST;
            baud_div_ff <= 12'h000;
            u2x_ff      <= 1'b0;
        end else if (wr_en) begin
            case (addr_ff)
                ADDR_CTRL_B:  ctrl_b_ff <= {hwdata[7:2], 1'b0, hwdata[0]};
                ADDR_CTRL_C:  ctrl_c_ff <= hwdata[7:0];
                ADDR_BAUD_LO: baud_div_ff[7:0] <= hwdata[7:0];
                ADDR_BAUD_HI: baud_div_ff[11:8] <= hwdata[3:0];
                ADDR_STAT_A:  u2x_ff <= hwdata[SA_U2X];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Baud generator and bit timing
    // ------------------------------------------------------------
    logic [11:0] baud_cnt_ff;
    logic        tick;
    logic [1:0]  xck_sync_ff, rxd_sync_ff;
    logic        xck_ff, xck_prev_ff;
    logic        xck_lvl, xck_rise, xck_fall, chg_ev, smp_ev;
    logic        sync_mode, master;
    logic [4:0]  os;

    assign tick      = baud_cnt_ff == 12'h000;
    assign sync_mode = ctrl_c_ff[CC_SYNC];
    assign master    = ctrl_c_ff[CC_MASTER];
    assign os        = u2x_ff ? OS_DOUBLE : OS_NORMAL;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            baud_cnt_ff <= 12'h000;
        end else if (tick || wr_lo) begin
            baud_cnt_ff <= wr_lo ? {baud_div_ff[11:8], hwdata[7:0]} : baud_div_ff;
        end else begin
            baud_cnt_ff <= baud_cnt_ff - 12'h001;
        end
    end

    // Pin inputs pass two flops before any logic looks at them
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            xck_sync_ff <= 2'b00;
            rxd_sync_ff <= 2'b11;
        end else begin
            xck_sync_ff <= {xck_sync_ff[0], transfer_clock_pin_i};
            rxd_sync_ff <= {rxd_sync_ff[0], serial_in_pin};
        end
    end

    // Master clock toggles each tick, so one bit lasts two ticks
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            xck_ff      <= 1'b0;
            xck_prev_ff <= 1'b0;
        end else begin
            if (tick && sync_mode && master) begin
                xck_ff <= !xck_ff;
            end
            xck_prev_ff <= xck_lvl;
        end
    end

    assign xck_lvl  = master ? xck_ff : xck_sync_ff[1];
    assign xck_rise = sync_mode && xck_lvl && !xck_prev_ff;
    assign xck_fall = sync_mode && !xck_lvl && xck_prev_ff;
    assign chg_ev   = ctrl_c_ff[CC_POL] ? xck_fall : xck_rise;
    assign smp_ev   = ctrl_c_ff[CC_POL] ? xck_rise : xck_fall;

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    usrt_tx_st_t tx_st_ff;
    logic [4:0]  tx_pre_ff;
    logic [12:0] tx_sh_ff;
    logic [3:0]  tx_cnt_ff, tx_len;
    logic [8:0]  tx_buf_ff;
    logic        tx_full_ff, txc_ff, txd_ff, tx_bit, tx_load, tx_done;
    logic [8:0]  wdat;
    logic        par;
    logic [12:0] frame;

    assign tx_bit  = sync_mode ? chg_ev : (tick && tx_pre_ff == os - 5'h01);
    assign tx_len  = 4'h2 + nbits + {3'b000, ctrl_c_ff[CC_PEN]} + {3'b000, ctrl_c_ff[CC_STOP2]};
    assign tx_done = tx_st_ff == TX_SHIFT && tx_bit && tx_cnt_ff == tx_len - 4'h1;
    assign tx_load = tx_full_ff && tx_bit && (tx_st_ff == TX_IDLE || tx_done);
    assign wdat    = {ctrl_b_ff[CB_TXD8], hwdata[7:0]} & cmask;
    assign par     = ^(tx_buf_ff & cmask) ^ ctrl_c_ff[CC_PODD];

    // Data, then parity, then stops, packed behind the start bit
    always_comb begin
        frame = 13'h1fff;
        frame[8:0] = tx_buf_ff | ~cmask;
        frame[nbits] = ctrl_c_ff[CC_PEN] ? par : 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_pre_ff <= 5'h00;
        end else if (tick) begin
            tx_pre_ff <= (tx_pre_ff >= os - 5'h01) ? 5'h00 : tx_pre_ff + 5'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_buf_ff  <= 9'h000;
            tx_full_ff <= 1'b0;
        end else if (wr_data) begin
            tx_buf_ff  <= wdat;
            tx_full_ff <= 1'b1;
        end else if (tx_load) begin
            tx_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_st_ff  <= TX_IDLE;
            tx_sh_ff  <= 13'h1fff;
            tx_cnt_ff <= 4'h0;
            txd_ff    <= 1'b1;
        end else if (tx_load) begin
            tx_st_ff  <= TX_SHIFT;
            tx_sh_ff  <= frame;
            tx_cnt_ff <= 4'h0;
            txd_ff    <= 1'b0;
        end else begin
            case (tx_st_ff)
                TX_IDLE: txd_ff <= 1'b1;
                TX_SHIFT: begin
                    if (tx_done) begin
                        tx_st_ff <= TX_IDLE;
                        txd_ff   <= 1'b1;
                    end else if (tx_bit) begin
                        txd_ff    <= tx_sh_ff[0];
                        tx_sh_ff  <= {1'b1, tx_sh_ff[12:1]};
                        tx_cnt_ff <= tx_cnt_ff + 4'h1;
                    end
                end
                default: tx_st_ff <= TX_IDLE;
            endcase
        end
    end

    // A completion in the same cycle as a clear keeps the flag set
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            txc_ff <= 1'b0;
        end else if (tx_done && !tx_full_ff) begin
            txc_ff <= 1'b1;
        end else if (irq_tx_complete_ack || (wr_en && addr_ff == ADDR_STAT_A && hwdata[SA_TXC])) begin
            txc_ff <= 1'b0;
        end
    end

    // Pin stays owned until everything queued has left
    assign serial_out_pin_oe = ctrl_b_ff[CB_TXON] || tx_full_ff || tx_st_ff == TX_SHIFT;
    assign serial_out_pin_o  = txd_ff;
    assign transfer_clock_pin_oe = sync_mode && master && (serial_out_pin_oe || rx_pin_owned);
    assign transfer_clock_pin_o  = xck_ff;
    assign irq_buf_empty   = ctrl_b_ff[CB_UDRIE] && !tx_full_ff;
    assign irq_tx_complete = ctrl_b_ff[CB_TXCIE] && txc_ff;

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    usrt_rx_st_t rx_st_ff;
    logic [4:0]  rx_cnt_ff;
    logic [3:0]  rx_bit_ff, rx_last;
    logic [8:0]  rx_sh_ff, rx_buf_ff;
    logic        rx_full_ff, rxd, rx_smp, rx_store, rx_en;

    assign rx_en        = ctrl_b_ff[CB_RXEN];
    assign rx_pin_owned = rx_en;
    assign rxd          = rxd_sync_ff[1];
    assign rx_smp       = sync_mode ? smp_ev : (tick && rx_cnt_ff == os - 5'h01);
    assign rx_last      = nbits + {3'b000, ctrl_c_ff[CC_PEN]};
    assign rx_store     = rx_st_ff == RX_DATA && rx_smp && rx_bit_ff == rx_last;

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !rx_en) begin
            rx_st_ff  <= RX_IDLE;
            rx_cnt_ff <= 5'h00;
            rx_bit_ff <= 4'h0;
            rx_sh_ff  <= 9'h000;
        end else begin
            if (tick) begin
                rx_cnt_ff <= (rx_cnt_ff >= os - 5'h01) ? 5'h00 : rx_cnt_ff + 5'h01;
            end
            case (rx_st_ff)
                RX_IDLE: begin
                    rx_bit_ff <= 4'h0;
                    rx_sh_ff  <= 9'h000;
                    if (!rxd && sync_mode && smp_ev) begin
                        rx_st_ff <= RX_DATA;
                    end else if (!rxd && !sync_mode) begin
                        rx_st_ff  <= RX_START;
                        rx_cnt_ff <= 5'h00;
                    end
                end
                // Recheck mid-bit so a glitch is not taken as a start
                RX_START: begin
                    if (tick && rx_cnt_ff == (os >> 1) - 5'h01) begin
                        rx_st_ff  <= rxd ? RX_IDLE : RX_DATA;
                        rx_cnt_ff <= 5'h00;
                    end
                end
                RX_DATA: begin
                    if (rx_smp) begin
                        if (rx_bit_ff < nbits) begin
                            rx_sh_ff[rx_bit_ff] <= rxd;
                        end
                        rx_bit_ff <= rx_bit_ff + 4'h1;
                        if (rx_store) begin
                            rx_st_ff <= RX_IDLE;
                        end
                    end
                end
                default: rx_st_ff <= RX_IDLE;
            endcase
        end
    end

    // New character wins over a read in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !rx_en) begin
            rx_full_ff <= 1'b0;
            rx_buf_ff  <= 9'h000;
        end else if (rx_store) begin
            rx_buf_ff  <= rx_sh_ff & cmask;
            rx_full_ff <= 1'b1;
        end else if (rd_data) begin
            rx_full_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = RD_UNMAPPED;
        case (addr_ff)
            ADDR_DATA:    rd_mux[7:0] = rx_buf_ff[7:0] & cmask[7:0];
            ADDR_STAT_A: begin
                rd_mux[SA_RXNEW] = rx_full_ff;
                rd_mux[SA_TXC]  = txc_ff;
                rd_mux[SA_UDRE] = !tx_full_ff;
                rd_mux[SA_U2X]  = u2x_ff;
            end
            ADDR_CTRL_B: begin
                rd_mux[7:0]    = ctrl_b_ff;
                rd_mux[CB_RXB8] = rx_buf_ff[8];
            end
            ADDR_CTRL_C:  rd_mux[7:0] = ctrl_c_ff;
            ADDR_BAUD_LO: rd_mux[7:0] = baud_div_ff[7:0];
            ADDR_BAUD_HI: rd_mux[3:0] = baud_div_ff[11:8];
            default: ;
        endcase
    end
endmodule // usrt_top

// *** usrt_pkg.sv ***
package usrt_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA    = 8'h00;
    localparam logic [7:0] ADDR_STAT_A  = 8'h04;
    localparam logic [7:0] ADDR_CTRL_B  = 8'h08;
    localparam logic [7:0] ADDR_CTRL_C  = 8'h0c;
    localparam logic [7:0] ADDR_BAUD_LO = 8'h10;
    localparam logic [7:0] ADDR_BAUD_HI = 8'h14;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SA_RXNEW = 7; // serial_status_a
    localparam int SA_TXC  = 6;
    localparam int SA_UDRE = 5;
    localparam int SA_U2X  = 1;
    localparam int CB_TXCIE = 6; // serial_control_b
    localparam int CB_UDRIE = 5;
    localparam int CB_RXEN  = 4;
    localparam int CB_TXON  = 3;
    localparam int CB_CSZ2  = 2;
    localparam int CB_RXB8  = 1;
    localparam int CB_TXD8  = 0;
    localparam int CC_MASTER = 7; // serial_control_c
    localparam int CC_SYNC   = 6;
    localparam int CC_PEN    = 5;
    localparam int CC_PODD   = 4;
    localparam int CC_STOP2  = 3;
    localparam int CC_CSZ_HI = 2;
    localparam int CC_CSZ_LO = 1;
    localparam int CC_POL    = 0;
    // ------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_C_RST  = 8'h06;  // 8 data bits
    localparam logic [2:0]  CSZ_NINE    = 3'h7;
    localparam logic [3:0]  CSZ_BASE    = 4'h5;
    localparam logic [4:0]  OS_NORMAL   = 5'h10;
    localparam logic [4:0]  OS_DOUBLE   = 5'h08;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    localparam logic [1:0]  HRESP_OKAY  = 2'h0;
    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} usrt_tx_st_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10
    } usrt_rx_st_t;
endpackage

// *** usrt_monitor.sv ***
`timescale 1ns/1ns
module usrt_monitor (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    // Register bus
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic [1:0] hresp,
    // Interrupts and pins
    input wire logic       irq_buf_empty,
    input wire logic       irq_tx_complete,
    input wire logic       irq_tx_complete_ack,
    input wire logic       serial_out_pin_o,
    input wire logic       serial_out_pin_oe,
    input wire logic       rx_pin_owned
);
    import usrt_pkg::*;
    logic wr_go;
    logic rd_go;
    assign wr_go = hsel & hready & htrans[1] & hwrite;
    assign rd_go = hsel & hready & htrans[1] & ~hwrite;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    rst_state_a: assert property ($past(sys_rst) |-> !serial_out_pin_oe && !rx_pin_owned
        && !irq_tx_complete && !irq_buf_empty) else $error("state after reset wrong");
    rd_wait_a: assert property (rd_go |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    wr_ready_a: assert property (wr_go |=> hreadyout)
        else $error("write not zero wait");
    resp_okay_a: assert property (hresp == HRESP_OKAY)
        else $error("bus response not okay");
    // Only a register write may end the buffer-empty request
    empty_hold_a: assert property (irq_buf_empty && !$past(wr_go) |=> irq_buf_empty)
        else $error("buffer empty request dropped");
    txc_hold_a: assert property (irq_tx_complete && !irq_tx_complete_ack
        && !$past(wr_go) |=> irq_tx_complete) else $error("complete request dropped");
    txc_ack_a: assert property (irq_tx_complete && irq_tx_complete_ack |=> !irq_tx_complete)
        else $error("service did not clear complete");
    tx_own_a: assert property ($rose(serial_out_pin_oe) |-> $past(wr_go, 2))
        else $error("tx pin taken without write");
    rx_own_a: assert property ($changed(rx_pin_owned) |-> $past(wr_go, 2))
        else $error("rx pin ownership changed without write");
    out_idle_a: assert property (!serial_out_pin_oe |-> serial_out_pin_o)
        else $error("released tx line not high");
    start_len_a: assert property ($fell(serial_out_pin_o) |-> (!serial_out_pin_o)[*2])
        else $error("start bit too short");
    cover property (rd_go);
    cover property (irq_tx_complete && irq_tx_complete_ack);
    cover property ($fell(serial_out_pin_oe));
endmodule // usrt_monitor
bind usrt_top usrt_monitor u_mon (.*);

// *** usrt_far.sv ***
`timescale 1ns/1ns
module usrt_far (
    // Line side
    input  wire logic        line_in,
    input  wire logic        line_oe,
    output logic             line_out,
    output logic             xck,
    // Format
    input  wire logic        sync_mode,
    input  wire logic        clk_run,
    input  wire logic [3:0]  nbits,
    input  wire logic        par_en,
    // Received frames, got toggles once per frame
    output logic      [11:0] got_word,
    output logic             got
);
    initial begin
        line_out = 1'b1;
        xck = 1'b0;
        got = 1'b0;
        got_word = 12'h0;
    end
    // Clock stands still at low outside a transfer window
    always begin
        #40;
        xck = clk_run ? ~xck : 1'b0;
    end
    // Bit pacing: async fixed bit time, sync on the change or sample edge
    task automatic step(input logic rise);
        if (!sync_mode) #160;
        else if (rise) @(posedge xck);
        else @(negedge xck);
    endtask
    // Start, data LSB first, parity, first stop; idle stays high
    task automatic send(input logic [11:0] w);
        #3;
        step(1'b1);
        line_out = 1'b0;
        for (int i = 0; i < nbits + par_en + 1; i++) begin
            step(1'b1);
            line_out = w[i];
        end
        step(1'b1);
    endtask
    always begin
        @(negedge line_in iff line_oe);
        if (sync_mode) @(negedge xck);
        else #80;
        got_word = 12'h0;
        for (int i = 0; i < nbits + par_en + 1; i++) begin
            step(1'b0);
            got_word[i] = line_in;
        end
        got = ~got;
    end
endmodule // usrt_far

// *** tb.sv ***
`timescale 1ns/1ns
module tb;
    import usrt_pkg::*;
    logic        sys_clk;
    logic        sys_rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        irq_buf_empty;
    logic        irq_tx_complete;
    logic        irq_tx_complete_ack;
    logic        tx_o, tx_oe, rx_i, xck, xck_oe;
    logic        sync_mode, clk_run;
    logic [3:0]  nb;
    logic        pe, po, t8;
    logic [8:0]  dmask;
    logic [11:0] got_word;
    logic        got;
    logic [11:0] exp_q[$];
    logic [31:0] rnd;
    int          error_cnt, comparisons, cycles;
    usrt_top DUT (
        .sys_clk              (sys_clk),
        .sys_rst              (sys_rst),
        .hsel                 (hsel),
        .haddr                (haddr),
        .htrans               (htrans),
        .hwrite               (hwrite),
        .hsize                (3'h2),
        .hready               (hreadyout),
        .hwdata               (hwdata),
        .hrdata               (hrdata),
        .hreadyout            (hreadyout),
        .hresp                (),
        .irq_buf_empty        (irq_buf_empty),
        .irq_tx_complete      (irq_tx_complete),
        .irq_tx_complete_ack  (irq_tx_complete_ack),
        .serial_out_pin_o     (tx_o),
        .serial_out_pin_oe    (tx_oe),
        .serial_in_pin        (rx_i),
        .rx_pin_owned         (),
        .transfer_clock_pin_i (xck),
        .transfer_clock_pin_o (),
        .transfer_clock_pin_oe(xck_oe)
    );
    usrt_far u_far (
        .line_in  (tx_o),
        .line_oe  (tx_oe),
        .line_out (rx_i),
        .xck      (xck),
        .sync_mode(sync_mode),
        .clk_run  (clk_run),
        .nbits    (nb),
        .par_en   (pe),
        .got_word (got_word),
        .got      (got)
    );
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Bits after the start bit as the line should carry them
    function automatic logic [11:0] line_word(input logic [8:0] d);
        logic [8:0] m;
        m = d & dmask;
        line_word = {3'h0, m};
        line_word[nb] = pe ? ^{m, po} : 1'b1;
        line_word[nb + 4'(pe)] = 1'b1;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        @(posedge sys_clk iff hreadyout === 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk iff hreadyout === 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask
    task automatic poll(input int b, input logic v);
        logic [31:0] r;
        bus(1'b0, ADDR_STAT_A, 32'h0, r);
        while (r[b] !== v) bus(1'b0, ADDR_STAT_A, 32'h0, r);
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Clock, timeout and frame watcher
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        #1;
        forever begin
            @(got);
            if (exp_q.size() == 0) chk(32'h1, 32'h0);
            else chk({20'h0, got_word}, {20'h0, exp_q.pop_front()});
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {sys_rst, hsel, haddr, htrans, hwrite, hwdata} = {2'b10, 67'h0};
        {irq_tx_complete_ack, sync_mode, clk_run, error_cnt, comparisons, cycles} = 0;
        {nb, pe, po, dmask, rnd} = {4'h8, 2'b00, 9'h0ff, 32'h996c4509};
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd_chk(ADDR_STAT_A, 32'hff, 32'h20);
        rd_chk(ADDR_CTRL_C, 32'hff, {24'h0, CTRL_C_RST});
        rd_chk(8'h18, 32'hffff_ffff, RD_UNMAPPED);
        chk({31'h0, tx_oe}, 32'h0);
        wr(ADDR_BAUD_LO, 32'h0);
        for (int i = 0; i < 5; i++) begin
            nb = 4'(i + 5);
            pe = (i != 0);
            po = (i == 2) || (i == 4);
            dmask = 9'((10'h1 << nb) - 10'h1);
            rnd = lfsr(rnd);
            t8 = rnd[8];
            wr(ADDR_CTRL_C, {26'h0, pe, po, i == 2, (i == 4) ? 2'h3 : 2'(i), 1'b0});
            wr(ADDR_CTRL_B, {24'h0, 5'h0f, i == 4, 1'b0, t8});
            @(posedge sys_clk);
            chk({31'h0, irq_buf_empty}, 32'h1);
            for (int k = 0; k < 2; k++) begin
                poll(SA_UDRE, 1'b1);
                rnd = lfsr(rnd);
                exp_q.push_back(line_word({t8, rnd[7:0]}));
                wr(ADDR_DATA, rnd);
            end
            rd_chk(ADDR_STAT_A, 32'h60, 32'h0);
            wait (exp_q.size() == 0);
            poll(SA_TXC, 1'b1);
            chk({31'h0, irq_tx_complete}, 32'h1);
            wr(ADDR_STAT_A, 32'h0);
            rd_chk(ADDR_STAT_A, 32'h40, 32'h40);
            if (i[0]) begin
                irq_tx_complete_ack <= 1'b1;
                @(posedge sys_clk);
                irq_tx_complete_ack <= 1'b0;
            end else begin
                wr(ADDR_STAT_A, 32'h40);
            end
            rd_chk(ADDR_STAT_A, 32'h40, 32'h0);
            rnd = lfsr(rnd);
            u_far.send(line_word(rnd[8:0]));
            poll(SA_RXNEW, 1'b1);
            rd_chk(ADDR_CTRL_B, 32'h2, {30'h0, rnd[8] & dmask[8], 1'b0});
            rd_chk(ADDR_DATA, 32'hffff_ffff, {24'h0, rnd[7:0] & dmask[7:0]});
            rd_chk(ADDR_STAT_A, 32'h80, 32'h0);
        end
        // Disable right behind a write: the pending frame must still go out
        rnd = lfsr(rnd);
        exp_q.push_back(line_word({t8, rnd[7:0]}));
        wr(ADDR_DATA, rnd);
        wr(ADDR_CTRL_B, {24'h0, 7'h0a, t8});
        @(posedge sys_clk);
        chk({31'h0, tx_oe}, 32'h1);
        poll(SA_TXC, 1'b1);
        chk({31'h0, tx_oe}, 32'h0);
        wr(ADDR_STAT_A, 32'h40);
        // Synchronous slave, both directions at once on the far side's clock
        {nb, pe, dmask, sync_mode, clk_run} = {4'h8, 1'b0, 9'h0ff, 2'b11};
        wr(ADDR_CTRL_C, 32'h46);
        wr(ADDR_CTRL_B, 32'h18);
        chk({31'h0, xck_oe}, 32'h0);
        rnd = lfsr(rnd);
        exp_q.push_back(line_word({1'b0, rnd[7:0]}));
        wr(ADDR_DATA, rnd);
        u_far.send(line_word(rnd[15:7]));
        poll(SA_RXNEW, 1'b1);
        rd_chk(ADDR_DATA, 32'hff, {24'h0, rnd[14:7]});
        wait (exp_q.size() == 0);
        poll(SA_TXC, 1'b1);
        // Clock master: the block must now drive the transfer clock pin
        wr(ADDR_CTRL_C, 32'hc6);
        @(posedge sys_clk);
        chk({31'h0, xck_oe}, 32'h1);
        clk_run = 1'b0;
        complete_run();
    end
endmodule // tb
